// ==== qqr_pkg.sv ====
/*
  constants and types shared by the queue read port, its two-entry buffer and the offset serial port.
  assumes nothing of its surroundings.
*/
package qqr_pkg;
  localparam int QQR_QUEUES = 4;
  localparam int QQR_LANE_W = 10;
  localparam int QQR_BUS_W = 40;
  localparam int QQR_OFF_W = 16;
  localparam int QQR_CHAIN_W = 2 * QQR_OFF_W;
  localparam int QQR_BUF_DEPTH = 2;

  localparam logic [QQR_OFF_W-1:0] QQR_AE_OFF_RESET = 16'h007f;
  localparam logic [QQR_OFF_W-1:0] QQR_AF_OFF_RESET = 16'h007f;

  localparam logic [QQR_BUS_W-1:0] QQR_MASK_X10 = 40'h00000003ff;
  localparam logic [QQR_BUS_W-1:0] QQR_MASK_X20 = 40'h00000fffff;
  localparam logic [QQR_BUS_W-1:0] QQR_MASK_X40 = 40'hffffffffff;

  localparam logic [3:0] QQR_LANES_X10 = 4'h1;
  localparam logic [3:0] QQR_LANES_X20 = 4'h3;
  localparam logic [3:0] QQR_LANES_X40 = 4'hf;

  typedef enum logic [1:0] {
    QQR_WIDTH_X10 = 2'b00,
    QQR_WIDTH_X20 = 2'b01,
    QQR_WIDTH_X40 = 2'b10,
    QQR_WIDTH_RSVD = 2'b11
  } qqr_width_type;

  typedef enum logic {
    QQR_MODE_MUX = 1'b0,
    QQR_MODE_SPLIT = 1'b1
  } qqr_mode_type;
endpackage

// ==== qqr_buf_if.sv ====
/*
  valid/ready carrier between the read port and one two-entry queue buffer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface qqr_buf_if;
  logic in_valid;
  logic in_ready;
  logic [39:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [39:0] out_data;

  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
endinterface

// ==== qqr_pair_buf.sv ====
/*
  two-entry buffer with valid and ready on both sides; ready on the filling side is a register.
  assumes a synchronous active-high reset on the same clock as both sides.
*/
`timescale 1ns/1ps
module qqr_pair_buf
  import qqr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  qqr_buf_if.store bus
);
  logic [1:0] count_ff;
  logic [39:0] head_ff;
  logic [39:0] tail_ff;
  logic in_ready_ff;

  wire push = bus.in_valid & in_ready_ff;
  wire pop = bus.out_valid & bus.out_ready;
  wire [1:0] nxt_count = 2'(count_ff + {1'b0, push} - {1'b0, pop});
  // where the new word lands once any pop has moved the tail forward
  wire push_to_head = push & ((count_ff == 2'h0) | ((count_ff == 2'h1) & pop));
  wire push_to_tail = push & ~push_to_head;
  wire [39:0] nxt_head = push_to_head ? bus.in_data : (pop ? tail_ff : head_ff);
  wire [39:0] nxt_tail = push_to_tail ? bus.in_data : tail_ff;

  assign bus.in_ready = in_ready_ff;
  assign bus.out_valid = (count_ff != 2'h0);
  assign bus.out_data = head_ff;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      count_ff <= 2'h0;
      in_ready_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != 2'(QQR_BUF_DEPTH));
    end
  end

  always_ff @(posedge mclk_i) begin
    head_ff <= nxt_head;
    tail_ff <= nxt_tail;
  end
endmodule

// ==== qqr_read_port.sv ====
/*
  read side of a four-queue buffer: one 4:1 multiplexed read port or four split 10-bit ports,
  single or double rate fixed at master reset, plus the serial port for the almost-empty and
  almost-full offsets on its own serial clock.
  assumes read clocks, enables, selects and output enables are slow pins sampled on mclk_i;
  the serial enables and serial input are synchronous to the serial clock.
*/
`timescale 1ns/1ps
module qqr_read_port
  import qqr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic master_reset_n_i,
  input wire logic read_rate_select_i,
  input wire logic [1:0] read_width_code_i,
  input wire logic queue_mode_i,
  input wire logic [1:0] queue_output_select_i,
  input wire logic [3:0] port_read_clock_i,
  input wire logic [3:0] port_read_enable_n_i,
  input wire logic [3:0] port_read_select_n_i,
  input wire logic [3:0] port_output_enable_n_i,
  input wire logic [3:0][39:0] queue_word_i,
  input wire logic [3:0] queue_valid_i,
  output logic [3:0] queue_ready_o,
  output logic [39:0] read_data_o,
  output logic [3:0] read_data_oe_o,
  output logic [3:0] read_strobe_o,
  input wire logic offset_serial_clock_i,
  input wire logic offset_serial_in_i,
  input wire logic offset_load_enable_n_i,
  input wire logic offset_readback_enable_n_i,
  output logic offset_serial_out_o,
  output logic [15:0] almost_empty_offset_o,
  output logic [15:0] almost_full_offset_o
);
  // pin synchronisers, first stage feeds only the second
  logic [3:0] rclk_s1_ff, rclk_s2_ff, rclk_s3_ff;
  logic [3:0] ren_s1_ff, ren_s2_ff;
  logic [3:0] rcs_s1_ff, rcs_s2_ff;
  logic [3:0] oe_s1_ff, oe_s2_ff;
  logic [1:0] os_s1_ff, os_s2_ff;
  logic [1:0] ow_s1_ff, ow_s2_ff;
  logic mrs_s1_ff, mrs_s2_ff;
  logic rdr_s1_ff, rdr_s2_ff;
  logic mode_s1_ff, mode_s2_ff;

  always_ff @(posedge mclk_i) begin
    rclk_s1_ff <= port_read_clock_i;
    rclk_s2_ff <= rclk_s1_ff;
    rclk_s3_ff <= rclk_s2_ff;
    ren_s1_ff <= port_read_enable_n_i;
    ren_s2_ff <= ren_s1_ff;
    rcs_s1_ff <= port_read_select_n_i;
    rcs_s2_ff <= rcs_s1_ff;
    oe_s1_ff <= port_output_enable_n_i;
    oe_s2_ff <= oe_s1_ff;
    os_s1_ff <= queue_output_select_i;
    os_s2_ff <= os_s1_ff;
    ow_s1_ff <= read_width_code_i;
    ow_s2_ff <= ow_s1_ff;
    mrs_s1_ff <= master_reset_n_i;
    mrs_s2_ff <= mrs_s1_ff;
    rdr_s1_ff <= read_rate_select_i;
    rdr_s2_ff <= rdr_s1_ff;
    mode_s1_ff <= queue_mode_i;
    mode_s2_ff <= mode_s1_ff;
  end

  // configuration caught while master reset is held
  logic ddr_ff;
  qqr_width_type width_ff;
  qqr_mode_type mode_ff;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ddr_ff <= 1'b0;
      width_ff <= QQR_WIDTH_X10;
      mode_ff <= QQR_MODE_MUX;
    end else if (!mrs_s2_ff) begin
      ddr_ff <= rdr_s2_ff;
      width_ff <= qqr_width_type'(ow_s2_ff);
      mode_ff <= qqr_mode_type'(mode_s2_ff);
    end
  end

  wire is_mux = (mode_ff == QQR_MODE_MUX);
  wire [3:0] rise = rclk_s2_ff & ~rclk_s3_ff;
  wire [3:0] fall = ~rclk_s2_ff & rclk_s3_ff;
  wire [3:0] edge_hit = rise | (fall & {4{ddr_ff}});
  wire [3:0] port_req = edge_hit & ~ren_s2_ff & ~rcs_s2_ff;
  // mux mode looks at port 0 alone
  wire [3:0] port_fire = is_mux ? {3'h0, port_req[0]} : port_req;

  // queue select is taken on read clock 0 rising edges
  logic [1:0] sel_ff;
  wire [1:0] sel_now = rise[0] ? os_s2_ff : sel_ff;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sel_ff <= 2'h0;
    end else if (rise[0]) begin
      sel_ff <= os_s2_ff;
    end
  end

  // reserved width code behaves as x10
  wire [QQR_BUS_W-1:0] width_mask = (width_ff == QQR_WIDTH_X20) ? QQR_MASK_X20 :
                                    (width_ff == QQR_WIDTH_X40) ? QQR_MASK_X40 : QQR_MASK_X10;
  wire [3:0] width_lanes = (width_ff == QQR_WIDTH_X20) ? QQR_LANES_X20 :
                           (width_ff == QQR_WIDTH_X40) ? QQR_LANES_X40 : QQR_LANES_X10;

  logic [3:0] head_valid;
  logic [3:0][39:0] head_word;
  logic [3:0] pop_req;
  wire mux_pop = port_fire[0] & head_valid[sel_now];
  wire [QQR_BUS_W-1:0] mux_word = head_word[sel_now] & width_mask;
  logic [QQR_BUS_W-1:0] q_data_ff;
  logic [3:0] oe_ff;
  logic [3:0] strobe_ff;
  logic [QQR_BUS_W-1:0] nxt_q_data;
  logic [3:0] nxt_strobe;
  // lanes beyond the active mux width stay floated
  wire [3:0] nxt_oe = is_mux ? ({4{~oe_s2_ff[0]}} & width_lanes) : ~oe_s2_ff;

  genvar g;
  generate
    for (g = 0; g < QQR_QUEUES; g++) begin : g_queue
      qqr_buf_if qbus ();
      qqr_pair_buf u_buf (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .bus(qbus.store)
      );
      assign qbus.in_valid = queue_valid_i[g];
      assign qbus.in_data = queue_word_i[g];
      assign qbus.out_ready = pop_req[g];
      assign queue_ready_o[g] = qbus.in_ready;
      assign head_valid[g] = qbus.out_valid;
      assign head_word[g] = qbus.out_data;
      assign pop_req[g] = is_mux ? (mux_pop & (sel_now == 2'(g))) : (port_fire[g] & head_valid[g]);
      assign nxt_strobe[g] = pop_req[g];
      // split modes: lane g carries only queue g
      assign nxt_q_data[QQR_LANE_W*g +: QQR_LANE_W] =
        is_mux ? (mux_pop ? mux_word[QQR_LANE_W*g +: QQR_LANE_W] : q_data_ff[QQR_LANE_W*g +: QQR_LANE_W]) :
                 (pop_req[g] ? head_word[g][QQR_LANE_W-1:0] : q_data_ff[QQR_LANE_W*g +: QQR_LANE_W]);
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      q_data_ff <= '0;
      oe_ff <= 4'h0;
      strobe_ff <= 4'h0;
    end else begin
      q_data_ff <= nxt_q_data;
      oe_ff <= nxt_oe;
      strobe_ff <= nxt_strobe;
    end
  end

  assign read_data_o = q_data_ff;
  assign read_data_oe_o = oe_ff;
  assign read_strobe_o = strobe_ff;

  // resets carried into the serial clock domain
  logic srst_src_ff, smrs_src_ff;
  always_ff @(posedge mclk_i) begin
    srst_src_ff <= reset_i;
    smrs_src_ff <= reset_i | ~mrs_s2_ff;
  end

  logic srst_s1_ff, srst_s2_ff, smrs_s1_ff, smrs_s2_ff;
  logic [QQR_CHAIN_W-1:0] chain_ff;
  logic [QQR_CHAIN_W-1:0] rb_shift_ff;
  logic rb_on_ff;
  logic [QQR_CHAIN_W-1:0] xfer_ff;
  logic req_ff;
  logic ack_s1_ff, ack_s2_ff;
  logic ack_ff;

  wire [QQR_CHAIN_W-1:0] chain_reset = {QQR_AE_OFF_RESET, QQR_AF_OFF_RESET};
  wire load_on = ~offset_load_enable_n_i;
  wire rb_req = ~offset_readback_enable_n_i;
  wire [QQR_CHAIN_W-1:0] nxt_chain = {chain_ff[QQR_CHAIN_W-2:0], offset_serial_in_i};
  wire [QQR_CHAIN_W-1:0] nxt_rb = rb_on_ff ? {rb_shift_ff[QQR_CHAIN_W-2:0], 1'b0} : chain_ff;
  wire hs_idle = (req_ff == ack_s2_ff);

  always_ff @(posedge offset_serial_clock_i) begin
    srst_s1_ff <= srst_src_ff;
    srst_s2_ff <= srst_s1_ff;
    smrs_s1_ff <= smrs_src_ff;
    smrs_s2_ff <= smrs_s1_ff;
    ack_s1_ff <= ack_ff;
    ack_s2_ff <= ack_s1_ff;
  end

  // offsets shift in place while loading; readback never writes them
  always_ff @(posedge offset_serial_clock_i) begin
    if (smrs_s2_ff) begin
      chain_ff <= chain_reset;
    end else if (load_on) begin
      chain_ff <= nxt_chain;
    end
  end

  always_ff @(posedge offset_serial_clock_i) begin
    if (srst_s2_ff) begin
      rb_shift_ff <= '0;
      rb_on_ff <= 1'b0;
    end else begin
      rb_on_ff <= rb_req;
      if (rb_req) begin
        rb_shift_ff <= nxt_rb;
      end
    end
  end

  assign offset_serial_out_o = rb_shift_ff[QQR_CHAIN_W-1];

  // toggle handshake hands the offset word to the main clock
  always_ff @(posedge offset_serial_clock_i) begin
    if (srst_s2_ff) begin
      xfer_ff <= chain_reset;
      req_ff <= 1'b0;
    end else if (hs_idle && (xfer_ff != chain_ff)) begin
      xfer_ff <= chain_ff;
      req_ff <= ~req_ff;
    end
  end

  logic req_s1_ff, req_s2_ff;
  logic [QQR_OFF_W-1:0] ae_off_ff, af_off_ff;

  always_ff @(posedge mclk_i) begin
    req_s1_ff <= req_ff;
    req_s2_ff <= req_s1_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
      ae_off_ff <= QQR_AE_OFF_RESET;
      af_off_ff <= QQR_AF_OFF_RESET;
    end else if (req_s2_ff != ack_ff) begin
      ack_ff <= req_s2_ff;
      ae_off_ff <= xfer_ff[QQR_CHAIN_W-1:QQR_OFF_W];
      af_off_ff <= xfer_ff[QQR_OFF_W-1:0];
    end
  end

  assign almost_empty_offset_o = ae_off_ff;
  assign almost_full_offset_o = af_off_ff;
endmodule

// ==== qqr_src.sv ====
/*
  queue source model: offers each queue a word built from queue number and word count.
  assumes reset_i is synchronous, active high, on mclk_i.
*/
`timescale 1ns/1ps
module qqr_src
  import qqr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [3:0] ready_i,
  output logic [3:0] valid_o,
  output logic [3:0][39:0] word_o
);
  logic [3:0][3:0] idx_ff;
  always_ff @(posedge mclk_i) begin
    for (int n = 0; n < QQR_QUEUES; n++) begin
      idx_ff[n] <= reset_i ? 4'h0 : idx_ff[n] + 4'(valid_o[n] & ready_i[n]);
    end
  end
  always_comb begin
    for (int n = 0; n < QQR_QUEUES; n++) begin
      word_o[n] = {5{4'(n), idx_ff[n]}};
      valid_o[n] = !reset_i;
    end
  end
endmodule

// ==== qqr_read_port_chk.sv ====
/*
  assertions on the queue read port pins.
  assumes it is bound to qqr_read_port and that read pins move at most every 3 mclk cycles.
*/
`timescale 1ns/1ps
module qqr_read_port_chk
  import qqr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic master_reset_n_i,
  input wire logic [1:0] read_width_code_i,
  input wire logic queue_mode_i,
  input wire logic [3:0] port_read_clock_i,
  input wire logic [3:0] port_read_enable_n_i,
  input wire logic [3:0] port_read_select_n_i,
  input wire logic [3:0] port_output_enable_n_i,
  input wire logic [39:0] read_data_o,
  input wire logic [3:0] read_data_oe_o,
  input wire logic [3:0] read_strobe_o,
  input wire logic offset_serial_clock_i,
  input wire logic offset_load_enable_n_i,
  input wire logic offset_readback_enable_n_i,
  input wire logic offset_serial_out_o
);
  logic mux_ff;
  logic [1:0] wid_ff;
  wire logic [39:0] mask;
  wire logic rd = read_strobe_o != 4'h0;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mux_ff <= 1'b1;
      wid_ff <= 2'b00;
    end else if (!master_reset_n_i) begin
      mux_ff <= queue_mode_i == QQR_MODE_MUX;
      wid_ff <= read_width_code_i;
    end
  end
  assign mask = wid_ff == QQR_WIDTH_X40 ? QQR_MASK_X40 : wid_ff == QQR_WIDTH_X20 ? QQR_MASK_X20 : QQR_MASK_X10;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  strobe_pulse_a: assert property (rd |=> (read_strobe_o & $past(read_strobe_o)) == 4'h0)
    else $error("strobe held over a cycle");
  mux_clock_a: assert property (mux_ff && rd |-> $past(port_read_clock_i[0], 2) != $past(port_read_clock_i[0], 5))
    else $error("mux read without clock 0 edge");
  split_clock_a: assert property (!mux_ff && rd |->
    (read_strobe_o & ~($past(port_read_clock_i, 2) ^ $past(port_read_clock_i, 5))) == 4'h0)
    else $error("split read without own clock edge");
  mux_enable_a: assert property (mux_ff && rd |-> !$past(port_read_enable_n_i[0], 3) && !$past(port_read_select_n_i[0], 3))
    else $error("mux read while port 0 disabled");
  split_enable_a: assert property (!mux_ff && rd |->
    (read_strobe_o & ($past(port_read_enable_n_i, 3) | $past(port_read_select_n_i, 3))) == 4'h0)
    else $error("split read while port disabled");
  mux_width_a: assert property (mux_ff && rd |-> (read_data_o & ~mask) == 40'h0)
    else $error("bits above read width driven");
  lane_drive_a: assert property ($stable(port_output_enable_n_i)[*5] |-> read_data_oe_o[0] == !port_output_enable_n_i[0])
    else $error("lane 0 drive not following enable");
  data_hold_a: assert property (!rd && master_reset_n_i && $past(master_reset_n_i, 4) |-> $stable(read_data_o))
    else $error("read data moved without a read");
  serial_idle_a: assert property (@(posedge offset_serial_clock_i) disable iff (reset_i)
    offset_load_enable_n_i && offset_readback_enable_n_i |=> $stable(offset_serial_out_o))
    else $error("serial out moved while idle");
  cover property (mux_ff && rd);
  cover property (!mux_ff && read_strobe_o[3]);
  cover property (@(posedge offset_serial_clock_i) !offset_readback_enable_n_i);
endmodule
bind qqr_read_port qqr_read_port_chk i_qqr_read_port_chk (.*);

// ==== tb.sv ====
/*
  testbench for the queue read port: mux reads per width code, refusals, split double-rate
  reads, output enables, serial offset load and readback.
  assumes qqr_src feeds the queues and the checker is bound separately.
*/
`timescale 1ns/1ps
module tb
  import qqr_pkg::*;
;
  logic mclk = 0, sclk = 0, srun = 1, rst = 1, mr_n = 1, rdsel = 0, mode = 0, si = 0;
  logic ld_n = 1, rb_n = 1;
  logic [1:0] wcode = 2'b00, qsel = 2'b00;
  logic [3:0] rclk = 0, en_n = 4'hf, cs_n = 4'hf, oe_n = 4'h0, valid, ready, stb, oe, hit_s;
  logic [3:0][39:0] word;
  logic [39:0] rdata, hit_d, x;
  logic sout;
  logic [15:0] ae, af;
  int bad_count = 0, checks_done = 0, pops[4] = '{0, 0, 0, 0};
  always #20 mclk = ~mclk;
  initial begin
    #7;
    forever #15 sclk = srun & ~sclk;
  end
  qqr_read_port i_qqr_read_port (.mclk_i(mclk), .reset_i(rst), .master_reset_n_i(mr_n),
    .read_rate_select_i(rdsel), .read_width_code_i(wcode), .queue_mode_i(mode), .queue_output_select_i(qsel),
    .port_read_clock_i(rclk), .port_read_enable_n_i(en_n), .port_read_select_n_i(cs_n),
    .port_output_enable_n_i(oe_n), .queue_word_i(word), .queue_valid_i(valid), .queue_ready_o(ready),
    .read_data_o(rdata), .read_data_oe_o(oe), .read_strobe_o(stb), .offset_serial_clock_i(sclk),
    .offset_serial_in_i(si), .offset_load_enable_n_i(ld_n), .offset_readback_enable_n_i(rb_n),
    .offset_serial_out_o(sout), .almost_empty_offset_o(ae), .almost_full_offset_o(af));
  qqr_src i_qqr_src (.mclk_i(mclk), .reset_i(rst), .ready_i(ready), .valid_o(valid), .word_o(word));
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [39:0] wd(input int n);
    logic [7:0] b;
    b = {n[3:0], 4'(pops[n])};
    pops[n]++;
    return {5{b}};
  endfunction
  task automatic edge_rd(input int n, input logic v);
    hit_s = 4'h0;
    @(negedge mclk) rclk[n] = v;
    repeat (8) @(negedge mclk) if (stb != 4'h0) begin
      hit_s = stb;
      hit_d = rdata;
    end
  endtask
  task automatic mres(input logic m, input logic d, input logic [1:0] w);
    @(negedge mclk) begin
      mr_n = 0; mode = m; rdsel = d; wcode = w;
    end
    repeat (6) @(negedge mclk);
    mr_n = 1;
    repeat (5) @(negedge mclk);
  endtask
  task automatic t_mux;
    logic [39:0] m[4];
    logic [3:0] l[4];
    m = '{QQR_MASK_X10, QQR_MASK_X20, QQR_MASK_X40, QQR_MASK_X10};
    l = '{QQR_LANES_X10, QQR_LANES_X20, QQR_LANES_X40, QQR_LANES_X10};
    en_n = 4'he; cs_n = 4'he;
    for (int c = 0; c < 4; c++) begin
      mres(QQR_MODE_MUX, 1'b0, 2'(c));
      qsel = 2'(c);
      edge_rd(0, 1'b1);
      chk("mux strobe", 40'(hit_s), 40'(4'h1 << c));
      chk("mux data", hit_d, wd(c) & m[c]);
      chk("mux lanes", 40'(oe), 40'(l[c]));
      edge_rd(0, 1'b0);
      chk("single rate fall", 40'(hit_s), 40'h0);
    end
    en_n = 4'h1; cs_n = 4'h0;
    edge_rd(0, 1'b1);
    chk("port 0 disabled", 40'(hit_s), 40'h0);
    edge_rd(0, 1'b0);
    en_n = 4'h0;
    for (int n = 1; n < 4; n++) begin
      edge_rd(n, 1'b1);
      chk("mux other clock", 40'(hit_s), 40'h0);
      edge_rd(n, 1'b0);
    end
  endtask
  task automatic t_split;
    mres(QQR_MODE_SPLIT, 1'b1, 2'b00);
    // rate pin drops after capture; falling edges must still read
    rdsel = 1'b0;
    for (int n = 0; n < 4; n++) begin
      for (int e = 1; e >= 0; e--) begin
        edge_rd(n, e[0]);
        x = wd(n);
        chk("split strobe", 40'(hit_s), 40'(4'h1 << n));
        chk("split lane", 40'(hit_d[n*10 +: 10]), 40'(x[9:0]));
      end
    end
    cs_n = 4'h2;
    edge_rd(1, 1'b1);
    chk("split deselected", 40'(hit_s), 40'h0);
    oe_n = 4'h4;
    repeat (5) @(negedge mclk);
    chk("lane drive", 40'(oe), 40'h0b);
  endtask
  task automatic shift(input logic [31:0] p, input int k);
    for (int i = 31; i > 31 - k; i--) begin
      @(negedge sclk) begin
        ld_n = 0; si = p[i];
      end
    end
    @(negedge sclk) ld_n = 1;
    repeat (6) @(negedge sclk);
    repeat (6) @(negedge mclk);
  endtask
  task automatic t_serial;
    logic [31:0] p, got;
    p = 32'ha5c3_1e69;
    srun = 1;
    repeat (10) @(negedge sclk);
    shift(p, 16);
    chk("half load", {ae, af}, {QQR_AF_OFF_RESET, p[31:16]});
    shift(p << 16, 16);
    chk("full load", {ae, af}, p);
    for (int i = 31; i >= 0; i--) begin
      @(negedge sclk) rb_n = 0;
      @(posedge sclk) #1 got[i] = sout;
    end
    @(negedge sclk) rb_n = 1;
    chk("readback", got, p);
    repeat (6) @(negedge sclk);
    repeat (6) @(negedge mclk);
    chk("after readback", {ae, af}, p);
    srun = 0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(negedge mclk);
    rst = 0;
    repeat (10) @(negedge mclk);
    srun = 0;
    chk("reset offsets", {ae, af}, {QQR_AE_OFF_RESET, QQR_AF_OFF_RESET});
    t_mux;
    t_split;
    t_serial;
    tally_and_finish;
  end
endmodule
